// ==== hw/abeu_core.sv ====
// Add and branch execution unit with AXI4-Lite register access
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`include "abeu_map.svh"

module abeu_core
(
   // Clock, reset, enable
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic                  ce,
   // AXI4-Lite write address and data
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Data memory bank port
   output abeu_pkg::abeu_file_req_s   file_req,
   input  wire logic [7:0]            file_rdata,
   // Status
   output logic                       exec_busy
);

   // ----------------------------------------------------------
   // Timing summary
   // ----------------------------------------------------------
   // An instruction word written to the instruction register runs
   // for four clock cycles, one per phase:
   //    phase 0 decodes and steps the program counter by one word,
   //    phase 1 latches the literal or strobes the file read,
   //    phase 2 takes the file data and computes result and flags,
   //    phase 3 writes the destination and only the flags it owns.
   // A taken carry branch then spends four more idle phases.
   // Registers stay readable during a run, but a new instruction
   // word is dropped until the unit is idle again.
   // Limitation: file read data must be valid the cycle after the
   // read strobe, as the bank port has no wait input.

   // ----------------------------------------------------------
   // State
   // ----------------------------------------------------------
   abeu_pkg::abeu_state_s r_r;
   abeu_pkg::abeu_state_s r_nxt;
   logic [31:0]           wmask;
   logic [31:0]           wmerge_base;
   logic [31:0]           wmerged;

   // Byte lane mask from the held write strobes
   // Lanes with a low strobe keep their old contents
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_lane
         assign wmask[8*g +: 8] = {8{r_r.w_s[g]}};
      end
   endgenerate

   // Read-modify-write base for the addressed register
   // Unmapped offsets merge against zero; the write is refused there anyway
   always_comb
   begin
      case (r_r.aw_a)
         `ABEU_OFF_INSTR:  wmerge_base = {16'h0000, r_r.ir};
         `ABEU_OFF_ACC:    wmerge_base = {24'h000000, r_r.acc};
         `ABEU_OFF_STATUS: wmerge_base = {27'h0000000, r_r.stat};
         `ABEU_OFF_BANK:   wmerge_base = {28'h0000000, r_r.bank};
         `ABEU_OFF_PC:     wmerge_base = {11'h000, r_r.pc};
         default:          wmerge_base = 32'h00000000;
      endcase
   end

   // Merged word: new bytes where strobed, old bytes elsewhere
   assign wmerged = (wmerge_base & ~wmask) | (r_r.w_d & wmask);

   // ----------------------------------------------------------
   // Handshakes
   // ----------------------------------------------------------
   // Ready is withheld while frozen so nothing is taken on a dead cycle
   // A pending write answer also blocks both write channels
   assign s_axi_awready = ce & ~r_r.aw_v & ~r_r.b_v;
   assign s_axi_wready  = ce & ~r_r.w_v & ~r_r.b_v;
   assign s_axi_arready = ce & ~r_r.r_v;
   // Answers and the file port come straight from registered state
   assign s_axi_bvalid  = r_r.b_v;
   assign s_axi_bresp   = r_r.b_r;
   assign s_axi_rvalid  = r_r.r_v;
   assign s_axi_rdata   = r_r.r_d;
   assign s_axi_rresp   = r_r.r_r;
   assign file_req      = r_r.file;
   assign exec_busy     = (r_r.ex != abeu_pkg::EX_IDLE);

   // ----------------------------------------------------------
   // Next state
   // ----------------------------------------------------------
   always_comb
   begin
      logic [8:0]  sum;
      logic [4:0]  nib;
      logic [7:0]  a;
      logic [7:0]  b;
      logic        cin;
      logic [7:0]  fadr;
      logic        is_file;
      logic [20:0] offs;
      // Every working value is set here so no path can latch
      sum     = 9'h000;
      nib     = 5'h00;
      a       = r_r.acc;
      b       = 8'h00;
      cin     = 1'b0;
      fadr    = r_r.ir[7:0];
      is_file = (r_r.op == abeu_pkg::OP_ADD_FILE) || (r_r.op == abeu_pkg::OP_ADDC_FILE) ||
                (r_r.op == abeu_pkg::OP_AND_FILE);
      offs    = {{12{r_r.ir[7]}}, r_r.ir[7:0], 1'b0};
      // Everything holds by default; the file strobes last one cycle
      r_nxt   = r_r;
      r_nxt.file.rd = 1'b0;
      r_nxt.file.we = 1'b0;

      // Capture write address and data independently, in either order
      if (s_axi_awvalid && s_axi_awready)
      begin
         r_nxt.aw_v = 1'b1;
         r_nxt.aw_a = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         r_nxt.w_v = 1'b1;
         r_nxt.w_d = s_axi_wdata;
         r_nxt.w_s = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
         r_nxt.b_v = 1'b0;

      // Register write once both halves are held
      // The answer is raised with the update, so it follows the data
      if (r_r.aw_v && r_r.w_v && !r_r.b_v)
      begin
         r_nxt.aw_v = 1'b0;
         r_nxt.w_v  = 1'b0;
         r_nxt.b_v  = 1'b1;
         r_nxt.b_r  = `ABEU_RESP_OKAY;
         case (r_r.aw_a)
            `ABEU_OFF_INSTR:
            begin
               // A new word is refused while one is still executing
               if (r_r.ex == abeu_pkg::EX_IDLE)
               begin
                  r_nxt.ir = wmerged[15:0];
                  r_nxt.ex = abeu_pkg::EX_RUN;
                  r_nxt.q  = 2'h0;
               end
            end
            `ABEU_OFF_ACC:    r_nxt.acc  = wmerged[7:0];
            `ABEU_OFF_STATUS: r_nxt.stat = wmerged[4:0];
            `ABEU_OFF_BANK:   r_nxt.bank = wmerged[3:0];
            `ABEU_OFF_PC:     r_nxt.pc   = wmerged[20:0];
            `ABEU_OFF_STATE:  r_nxt.b_r  = `ABEU_RESP_OKAY;
            default:          r_nxt.b_r  = `ABEU_RESP_SLVERR;
         endcase
      end

      // Register read, answered one cycle after the address is taken
      // It sees the state as it stood before this cycle's execution step
      if (s_axi_rvalid && s_axi_rready)
         r_nxt.r_v = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         r_nxt.r_v = 1'b1;
         r_nxt.r_r = `ABEU_RESP_OKAY;
         case (s_axi_araddr)
            `ABEU_OFF_INSTR:  r_nxt.r_d = {16'h0000, r_r.ir};
            `ABEU_OFF_ACC:    r_nxt.r_d = {24'h000000, r_r.acc};
            `ABEU_OFF_STATUS: r_nxt.r_d = {27'h0000000, r_r.stat};
            `ABEU_OFF_BANK:   r_nxt.r_d = {28'h0000000, r_r.bank};
            `ABEU_OFF_PC:     r_nxt.r_d = {11'h000, r_r.pc};
            `ABEU_OFF_STATE:
               r_nxt.r_d = {26'h0000000, r_r.q, r_r.unsup, r_r.taken,
                            (r_r.ex == abeu_pkg::EX_FLUSH), (r_r.ex != abeu_pkg::EX_IDLE)};
            default:
            begin
               r_nxt.r_d = 32'h00000000;
               r_nxt.r_r = `ABEU_RESP_SLVERR;
            end
         endcase
      end

      // --------------------------------------------------------
      // Instruction sequencer; execution writes win over software
      // --------------------------------------------------------
      case (r_r.ex)
         abeu_pkg::EX_IDLE:
            r_nxt.q = 2'h0;
         abeu_pkg::EX_RUN:
         begin
            r_nxt.q = r_r.q + 2'h1;
            case (r_r.q)
               // Decode phase; the fetch address steps on by one word here
               2'h0:
               begin
                  r_nxt.taken = 1'b0;
                  r_nxt.pc    = r_r.pc + `ABEU_PC_STEP; // RL11
                  r_nxt.unsup = 1'b0;
                  if (r_r.ir[15:8] == `ABEU_OPC_ADD_IMM)
                     r_nxt.op = abeu_pkg::OP_ADD_IMM; // RL14
                  else if (r_r.ir[15:8] == `ABEU_OPC_AND_IMM)
                     r_nxt.op = abeu_pkg::OP_AND_IMM; // RL7
                  else if (r_r.ir[15:8] == `ABEU_OPC_BRANCH_C)
                     r_nxt.op = abeu_pkg::OP_BRANCH_C; // RL10
                  else if (r_r.ir[15:10] == `ABEU_OPC_ADD_FILE)
                     r_nxt.op = abeu_pkg::OP_ADD_FILE; // RL1
                  else if (r_r.ir[15:10] == `ABEU_OPC_ADDC_FILE)
                     r_nxt.op = abeu_pkg::OP_ADDC_FILE; // RL4
                  else if (r_r.ir[15:10] == `ABEU_OPC_AND_FILE)
                     r_nxt.op = abeu_pkg::OP_AND_FILE; // RL8
                  else
                  begin
                     // Foreign opcodes run as a plain four-phase no-op
                     r_nxt.op    = abeu_pkg::OP_NONE;
                     r_nxt.unsup = 1'b1;
                  end
               end
               // Operand read phase: literal, offset or file register
               // The access bank maps low offsets to bank zero, high ones to the top bank
               2'h1:
               begin
                  r_nxt.opnd = r_r.ir[7:0];
                  if (is_file)
                  begin
                     r_nxt.file.rd = 1'b1; // RL15
                     if (!r_r.ir[`ABEU_BIT_ACCESS])
                        r_nxt.file.addr = {(fadr < `ABEU_ACCESS_SPLIT) ? `ABEU_ACCESS_LO_BANK
                                           : `ABEU_ACCESS_HI_BANK, fadr}; // RL2
                     else
                        r_nxt.file.addr = {r_r.bank, fadr}; // RL12
                  end
               end
               // Compute phase; file data is valid the cycle after the read strobe
               2'h2:
               begin
                  b   = is_file ? file_rdata : r_r.opnd;
                  cin = (r_r.op == abeu_pkg::OP_ADDC_FILE) ? r_r.stat[`ABEU_ST_C] : 1'b0; // RL3
                  sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
                  nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
                  if ((r_r.op == abeu_pkg::OP_AND_IMM) || (r_r.op == abeu_pkg::OP_AND_FILE))
                     r_nxt.res = a & b; // RL6
                  else
                     r_nxt.res = sum[7:0];
                  r_nxt.flags[`ABEU_ST_C]  = sum[8]; // RL5
                  // AND classes fill these too; the flag mask drops them later
                  r_nxt.flags[`ABEU_ST_DIGIT] = nib[4];
                  r_nxt.flags[`ABEU_ST_OVFL]  = (a[7] == b[7]) && (sum[7] != a[7]);
                  r_nxt.flags[`ABEU_ST_N]  = r_nxt.res[7];
                  r_nxt.flags[`ABEU_ST_Z]  = (r_nxt.res == 8'h00);
                  r_nxt.taken = (r_r.op == abeu_pkg::OP_BRANCH_C) &&
                                r_r.stat[`ABEU_ST_C]; // RL9
               end
               // Write phase: destination, flags, program counter
               // A file destination leaves the accumulator as it was
               default:
               begin
                  r_nxt.ex = abeu_pkg::EX_IDLE;
                  case (r_r.op)
                     abeu_pkg::OP_ADD_IMM, abeu_pkg::OP_AND_IMM:
                        r_nxt.acc = r_r.res; // RL6 RL14
                     abeu_pkg::OP_ADD_FILE, abeu_pkg::OP_ADDC_FILE, abeu_pkg::OP_AND_FILE:
                     begin
                        if (r_r.ir[`ABEU_BIT_DEST])
                        begin
                           r_nxt.file.we    = 1'b1; // RL1 RL8
                           r_nxt.file.wdata = r_r.res;
                        end
                        else
                           r_nxt.acc = r_r.res; // RL1 RL3
                     end
                     abeu_pkg::OP_BRANCH_C:
                     begin
                        if (r_r.taken)
                        begin
                           r_nxt.pc = r_r.pc + offs; // RL11
                           r_nxt.ex = abeu_pkg::EX_FLUSH; // RL13
                        end
                     end
                     default:
                        r_nxt.ex = abeu_pkg::EX_IDLE;
                  endcase
                  // Only the flags each class owns are touched
                  if ((r_r.op == abeu_pkg::OP_ADD_IMM) || (r_r.op == abeu_pkg::OP_ADD_FILE) ||
                      (r_r.op == abeu_pkg::OP_ADDC_FILE))
                     r_nxt.stat = (r_r.stat & ~`ABEU_MASK_ADD) |
                                  (r_r.flags & `ABEU_MASK_ADD); // RL5
                  else if ((r_r.op == abeu_pkg::OP_AND_IMM) || (r_r.op == abeu_pkg::OP_AND_FILE))
                     r_nxt.stat = (r_r.stat & ~`ABEU_MASK_AND) |
                                  (r_r.flags & `ABEU_MASK_AND); // RL6 RL8
               end
            endcase
         end
         // Second cycle of a taken branch: four idle phases
         // No register or file strobe changes during these phases
         abeu_pkg::EX_FLUSH:
         begin
            r_nxt.q = r_r.q + 2'h1;
            if (r_r.q == `ABEU_LAST_PHASE)
               r_nxt.ex = abeu_pkg::EX_IDLE; // RL13
         end
         default:
         begin
            r_nxt.ex = abeu_pkg::EX_IDLE;
            r_nxt.q  = 2'h0;
         end
      endcase
   end

   // ----------------------------------------------------------
   // State register; clock enable freezes everything
   // Reset wins over the enable, so a frozen unit can still be reset
   // ----------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         r_r            <= '0;
         r_r.ex         <= abeu_pkg::EX_IDLE;
         r_r.op         <= abeu_pkg::OP_NONE;
         r_r.acc        <= `ABEU_RST_ACC;
         r_r.stat       <= `ABEU_RST_STATUS;
         r_r.bank       <= `ABEU_RST_BANK;
         r_r.pc         <= `ABEU_RST_PC;
      end
      else if (ce)
         r_r <= r_nxt;
   end

endmodule // abeu_core

// ==== hw/abeu_map.svh ====
// Offsets, field positions, opcodes and counts for the add and branch execution unit
//
// Overview of operation
// [RL1] Add accumulator to file, destination bit picks target
// [RL2] Access bit clear uses access bank, ignores bank
// [RL3] Add with carry sums accumulator, carry, file
// [RL4] Add with carry decoded from upper 0010 00da
// [RL5] Adds update negative, overflow, carry, digit carry, zero
// [RL6] AND immediate into accumulator, only negative, zero
// [RL7] AND immediate decoded from upper byte 0000 1011
// [RL8] AND with file 0001 01da, destination bit target
// [RL9] Carry branch taken only when carry is one
// [RL10] Carry branch upper byte 1110 0010, signed offset
// [RL11] Taken branch: incremented address plus twice offset
// [RL12] Access bit set leaves bank register addressing
// [RL13] Program counter change costs a second no-op cycle
// [RL14] Add immediate 0000 1111 updates all five flags
// [RL15] Four phases: decode, read, compute, write
`ifndef ABEU_MAP_SVH
`define ABEU_MAP_SVH

// -------------------------------------------------------------
// Register offsets (byte addresses)
// -------------------------------------------------------------
`define ABEU_OFF_INSTR   8'h00
`define ABEU_OFF_ACC     8'h04
`define ABEU_OFF_STATUS  8'h08
`define ABEU_OFF_BANK    8'h0C
`define ABEU_OFF_PC      8'h10
`define ABEU_OFF_STATE   8'h14

// -------------------------------------------------------------
// Status bit positions and reset values
// -------------------------------------------------------------
`define ABEU_ST_C        0
`define ABEU_ST_DIGIT    1
`define ABEU_ST_Z        2
`define ABEU_ST_OVFL     3
`define ABEU_ST_N        4
`define ABEU_MASK_ADD    5'h1F
`define ABEU_MASK_AND    5'h14
`define ABEU_RST_ACC     8'h00
`define ABEU_RST_STATUS  5'h00
`define ABEU_RST_BANK    4'h0
`define ABEU_RST_PC      21'h000000

// -------------------------------------------------------------
// Opcode patterns
// -------------------------------------------------------------
`define ABEU_OPC_ADD_IMM    8'h0F
`define ABEU_OPC_AND_IMM    8'h0B
`define ABEU_OPC_BRANCH_C   8'hE2
`define ABEU_OPC_ADD_FILE   6'h09
`define ABEU_OPC_ADDC_FILE  6'h08
`define ABEU_OPC_AND_FILE   6'h05
`define ABEU_BIT_DEST       9
`define ABEU_BIT_ACCESS     8

// -------------------------------------------------------------
// Access bank split and timing
// -------------------------------------------------------------
`define ABEU_ACCESS_SPLIT   8'h80
`define ABEU_ACCESS_LO_BANK 4'h0
`define ABEU_ACCESS_HI_BANK 4'hF
`define ABEU_LAST_PHASE     2'h3
`define ABEU_PC_STEP        21'h000002
`define ABEU_RESP_OKAY      2'h0
`define ABEU_RESP_SLVERR    2'h2

`endif

// ==== hw/abeu_pkg.sv ====
// Types shared by the add and branch execution unit
package abeu_pkg;

   // Execution sequencer
   typedef enum logic [1:0] {EX_IDLE, EX_RUN, EX_FLUSH} abeu_exec_e;

   // Decoded instruction class
   typedef enum logic [2:0] {
      OP_NONE, OP_ADD_IMM, OP_ADD_FILE, OP_ADDC_FILE, OP_AND_IMM, OP_AND_FILE, OP_BRANCH_C
   } abeu_op_e;

   // Request to the data memory bank logic
   typedef struct packed {
      logic [11:0] addr;
      logic        rd;
      logic        we;
      logic [7:0]  wdata;
   } abeu_file_req_s;

   // Whole state of the unit
   typedef struct packed {
      logic           aw_v;
      logic [7:0]     aw_a;
      logic           w_v;
      logic [31:0]    w_d;
      logic [3:0]     w_s;
      logic           b_v;
      logic [1:0]     b_r;
      logic           r_v;
      logic [31:0]    r_d;
      logic [1:0]     r_r;
      abeu_exec_e     ex;
      logic [1:0]     q;
      logic [15:0]    ir;
      abeu_op_e       op;
      logic [7:0]     opnd;
      logic [7:0]     res;
      logic [4:0]     flags;
      logic           taken;
      logic           unsup;
      logic [7:0]     acc;
      logic [4:0]     stat;
      logic [3:0]     bank;
      logic [20:0]    pc;
      abeu_file_req_s file;
   } abeu_state_s;

endpackage

// ==== bench/abeu_core_monitor.sv ====
// Port assertions for the add and branch execution unit
`timescale 1ns/100ps

module abeu_core_monitor
(
   // Clock and reset
   input wire logic          aclk,
   input wire logic          aresetn,
   input wire logic          ce,
   // Bus handshakes
   input wire logic          s_axi_awready,
   input wire logic          s_axi_wready,
   input wire logic          s_axi_bvalid,
   input wire logic          s_axi_bready,
   input wire logic [1:0]    s_axi_bresp,
   input wire logic          s_axi_arvalid,
   input wire logic          s_axi_arready,
   input wire logic          s_axi_rvalid,
   input wire logic          s_axi_rready,
   input wire logic [31:0]   s_axi_rdata,
   // Execution side
   input wire abeu_pkg::abeu_file_req_s file_req,
   input wire logic          exec_busy
);
   // -------
   // Checks
   // -------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");

   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");

   property p_r_done;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_r_done: assert property (p_r_done) else $error("read answer repeated");

   property p_r_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_answer: assert property (p_r_answer) else $error("read answer late");

   property p_b_done;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_done: assert property (p_b_done) else $error("write answer repeated");

   property p_we_pulse;
      file_req.we |=> !file_req.we;
   endproperty
   a_we_pulse: assert property (p_we_pulse) else $error("file write strobe too long");

   // The read strobe lasts one phase and only inside a run
   property p_rd_pulse;
      file_req.rd |-> exec_busy ##1 !file_req.rd;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("file read strobe wrong");

   property p_we_rd;
      file_req.we |-> $past(file_req.rd, 2);
   endproperty
   a_we_rd: assert property (p_we_rd) else $error("file write without read");

   property p_busy_min;
      $rose(exec_busy) |-> exec_busy [*4];
   endproperty
   a_busy_min: assert property (p_busy_min) else $error("run shorter than four");

   property p_busy_max;
      $rose(exec_busy) |-> ##[4:8] !exec_busy;
   endproperty
   a_busy_max: assert property (p_busy_max) else $error("run longer than eight");

endmodule // abeu_core_monitor

// ==== bench/abeu_core_tb_top.sv ====
// Self-checking bench for the add and branch execution unit
`timescale 1ns/100ps

module abeu_core_tb_top;
   // --------
   // Signals
   // --------
   logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, rd_d = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, file_rdata;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        exec_busy, d, a, cin, tk, fl;
   abeu_pkg::abeu_file_req_s file_req;
   logic [7:0]  mem [4096];
   logic [33:0] q_r[$], q_b[$], q_w[$], q_n[$];
   int          n_fail = 0, comparisons = 0, t, busy_n = 0, op;
   logic [7:0]  acc, nacc, k, opnd, res;
   logic [8:0]  sum;
   logic [4:0]  st, nst, lo;
   logic [3:0]  bank;
   logic [20:0] pc, npc;
   logic [11:0] fa;
   logic [15:0] ins;

   abeu_core i_dut
   (
      .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .file_req,
      .file_rdata, .exec_busy
   );

   // 40 MHz clock
   always #12.5 aclk = ~aclk;

   // Bank memory answers after the strobe and scrambles its lines otherwise
   always @(posedge aclk)
      rd_d <= file_req.rd;
   assign file_rdata = (file_req.rd || rd_d) ? mem[file_req.addr] : ~mem[file_req.addr];

   // --------
   // Checking
   // --------
   task automatic stop_test();
      n_fail += q_r.size() + q_b.size() + q_w.size() + q_n.size();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic guard(input int n);
      if (n >= 50)
      begin
         n_fail++;
         stop_test();
      end
   endtask

   // An empty queue yields a float value so a stray result never matches
   task automatic take(input string w, ref logic [33:0] q[$], input logic [33:0] g);
      logic [33:0] e;
      e = (q.size() > 0) ? q.pop_front() : {34{1'bz}};
      comparisons++;
      if (g !== e)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask

   task automatic cmp_rd(input logic [33:0] g);
      take("read", q_r, g);
   endtask
   task automatic cmp_b(input logic [33:0] g);
      take("write response", q_b, g);
   endtask
   task automatic cmp_w(input logic [33:0] g);
      take("file write", q_w, g);
   endtask
   task automatic cmp_n(input logic [33:0] g);
      take("busy length", q_n, g);
   endtask

   // Results are matched against the oldest note as they appear
   always @(posedge aclk)
   begin
      if (s_axi_rvalid && s_axi_rready)
         cmp_rd({s_axi_rresp, s_axi_rdata});
      if (s_axi_bvalid && s_axi_bready)
         cmp_b({32'h0, s_axi_bresp});
      if (aresetn && file_req.we)
      begin
         cmp_w({14'h0, file_req.addr, file_req.wdata});
         mem[file_req.addr] <= file_req.wdata;
      end
      if (exec_busy)
         busy_n <= busy_n + 1;
      else if (busy_n != 0)
      begin
         cmp_n(34'(busy_n));
         busy_n <= 0;
      end
   end

   // --------
   // Bus tasks
   // --------
   task automatic wr(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
      q_b.push_back({32'h0, er});
      @(posedge aclk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= dt;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      t = 0;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         t++;
      end
      while (!s_axi_bvalid && t < 50);
      s_axi_bready <= 1'b0;
      guard(t);
   endtask

   task automatic rd(input logic [7:0] ad, input logic [33:0] e);
      q_r.push_back(e);
      @(posedge aclk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      t = 0;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         t++;
      end
      while (!s_axi_rvalid && t < 50);
      s_axi_rready <= 1'b0;
      guard(t);
   endtask

   // Reset, register map, then random instructions with a reference model
   initial
   begin
      void'($urandom(32'h80FD));
      for (int i = 0; i < 4096; i++)
         mem[i] = 8'(i * 37);
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 6; i++)
         rd(8'(i * 4), 34'h0);
      rd(8'h18, {2'h2, 32'h0});
      wr(8'h18, 32'h1, 2'h2);
      wr(8'h14, 32'hFF, 2'h0);
      rd(8'h14, 34'h0);
      // Only byte lane 1 of the program counter may change
      s_axi_wstrb <= 4'h2;
      wr(8'h10, 32'h00123456, 2'h0);
      s_axi_wstrb <= 4'hF;
      rd(8'h10, 34'h3400);
      for (int i = 0; i < 80; i++)
      begin
         op = $urandom_range(6);
         {acc, k, st, bank, d, a} = 27'($urandom);
         pc = 21'($urandom) & 21'h1FFFFE;
         fl = (op == 1 || op == 2 || op == 4);
         fa = a ? {bank, k} : {(k < 8'h80) ? 4'h0 : 4'hF, k};
         mem[fa] = 8'($urandom);
         case (op)
            0: ins = {8'h0F, k};
            1: ins = {6'h09, d, a, k};
            2: ins = {6'h08, d, a, k};
            3: ins = {8'h0B, k};
            4: ins = {6'h05, d, a, k};
            5: ins = {8'hE2, k};
            default: ins = {8'h00, k};
         endcase
         opnd = fl ? mem[fa] : k;
         cin = (op == 2) && st[0];
         sum = acc + opnd + cin;
         lo = acc[3:0] + opnd[3:0] + cin;
         res = (op == 3 || op == 4) ? (acc & opnd) : sum[7:0];
         tk = (op == 5) && st[0];
         nst = (op >= 5) ? st : (op >= 3) ? {res[7], st[3], res == 8'h0, st[1:0]}
            : {res[7], acc[7] == opnd[7] && res[7] != acc[7], res == 8'h0, lo[4], sum[8]};
         npc = pc + 21'h2 + (tk ? {{12{k[7]}}, k, 1'b0} : 21'h0);
         nacc = (op >= 5 || (fl && d)) ? acc : res;
         if (fl && d)
            q_w.push_back({14'h0, fa, res});
         q_n.push_back(tk ? 34'h8 : 34'h4);
         wr(8'h04, {24'h0, acc}, 2'h0);
         wr(8'h08, {27'h0, st}, 2'h0);
         wr(8'h0C, {28'h0, bank}, 2'h0);
         wr(8'h10, {11'h0, pc}, 2'h0);
         wr(8'h00, {16'h0, ins}, 2'h0);
         t = 0;
         do
         begin
            @(posedge aclk);
            t++;
         end
         while (exec_busy && t < 50);
         guard(t);
         rd(8'h04, {26'h0, nacc});
         rd(8'h08, {29'h0, nst});
         rd(8'h10, {13'h0, npc});
         rd(8'h14, {30'h0, op == 6, tk, 2'h0});
         ce <= 1'b0;
         repeat (3) @(posedge aclk);
         ce <= 1'b1;
      end
      stop_test();
   end

endmodule // abeu_core_tb_top

bind abeu_core abeu_core_monitor i_mon
(
   .aclk, .aresetn, .ce, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .s_axi_rdata, .file_req, .exec_busy
);
